// ### bench/ctd_core_tb.sv
// Self-checking testbench of the decode and execute slice
`timescale 1ns/1ps
module ctd_core_tb;
  import ctd_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_ins_valid = 1'b0;
  logic [7:0] i_ins_op = 8'h00;
  logic [7:0] i_ins_b1 = 8'h00;
  logic [7:0] i_ins_b2 = 8'h00;
  logic [7:0] i_ins_b3 = 8'h00;
  logic [15:0] i_vec_data;
  logic o_ins_ready;
  logic [2:0] o_fetch_len;
  logic o_done;
  logic o_illegal;
  logic o_wdt_refresh;
  logic [8:0] o_vec_addr;
  logic [15:0] o_pc;
  logic [11:0] o_sp;
  logic [7:0] o_flags;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] pc_exp = 16'h0000;
  logic wdt_seen;
  // ----------------------------------------------------------------------
  // Instances, clock and timeout
  // ----------------------------------------------------------------------
  ctd_core ctd_core_inst (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ins_valid(i_ins_valid),
    .i_ins_op(i_ins_op), .i_ins_b1(i_ins_b1), .i_ins_b2(i_ins_b2),
    .i_ins_b3(i_ins_b3), .i_vec_data(i_vec_data),
    .o_ins_ready(o_ins_ready), .o_fetch_len(o_fetch_len),
    .o_done(o_done), .o_illegal(o_illegal),
    .o_wdt_refresh(o_wdt_refresh), .o_vec_addr(o_vec_addr),
    .o_pc(o_pc), .o_sp(o_sp), .o_flags(o_flags)
  );
  ctd_prog_mem ctd_prog_mem_inst (
    .i_vec_addr(o_vec_addr),
    .o_vec_data(i_vec_data)
  );
  // Free running clock
  always #10 i_clk = ~i_clk;
  // Cuts a hang short
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Mismatches %0d of %0d comparisons", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Offers one instruction, waits for its end, checks timing and length
  task automatic run(input logic [7:0] op, input logic [7:0] b1,
                     input logic [7:0] b2, input logic [7:0] b3,
                     input logic [2:0] len, input int cyc);
    int n;
    n = 0;
    @(posedge i_clk);
    i_ins_valid <= 1'b1;
    i_ins_op <= op;
    i_ins_b1 <= b1;
    i_ins_b2 <= b2;
    i_ins_b3 <= b3;
    // First pass is the taking edge, so a one-cycle illegal pulse is seen
    do begin
      @(posedge i_clk);
      i_ins_valid <= 1'b0;
      #1;
      n++;
    end while (o_done !== 1'b1 && o_illegal !== 1'b1 && n < 20);
    wdt_seen = o_wdt_refresh;
    pc_exp = (op === OP_TRAP) ? 16'h0AF5 : pc_exp + 16'(len);
    check(n, cyc + 1);
    check(o_illegal, cyc == 0);
    check(o_pc, pc_exp);
    if (len != 3'h0) begin
      check(o_fetch_len, len);
    end
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    @(posedge i_clk);
    #1;
    check(o_ins_ready, 1'b1);
    check({o_pc, o_sp}, 28'h0000000);
    check(o_flags, 8'h00);
    check({o_fetch_len, o_vec_addr}, 12'h000);
  endtask
  task automatic t_illegal();
    run(8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 0);
  endtask
  task automatic t_trap();
    run(OP_TRAP, 8'h05, 8'h00, 8'h00, LEN_2, 6);
    check(o_vec_addr, 9'h00A);
    check(o_sp, 12'hFFD);
    check(o_flags, 8'h00);
  endtask
  // Stack bytes FFE/FFF hold 00/02 after the trap
  task automatic t_wide();
    run(OP_WSUB_IM, 8'h01, 8'h0F, 8'hFE, LEN_4, 3);
    check(o_flags, 8'hAC);
    run(OP_MBTW_IM, 8'h40, 8'h0F, 8'hFE, LEN_4, 3);
    check(o_flags, 8'h8C);
    run(OP_CMTW_IM, 8'h40, 8'h0F, 8'hFE, LEN_4, 3);
    check(o_flags, 8'hCC);
    run(OP_MBTW_IM, 8'h80, 8'h0F, 8'hFE, LEN_4, 3);
    check(o_flags, 8'hAC);
    run(OP_WSUB_ER, 8'hFF, 8'hFF, 8'hFE, LEN_4, 3);
    check(o_flags, 8'h28);
    run(OP_MBTW_ER, 8'hFF, 8'hFF, 8'hFE, LEN_4, 3);
    check(o_flags, 8'h48);
    run(OP_CMTW_ER, 8'hFF, 8'hFF, 8'hFE, LEN_4, 3);
    check(o_flags, 8'h08);
    run(OP_WSUB_IM, 8'h7F, 8'h0F, 8'hFE, LEN_4, 3);
    check(o_flags, 8'h1C);
  endtask
  task automatic t_wdr();
    run(OP_WDR, 8'h00, 8'h00, 8'h00, LEN_1, 2);
    check(wdt_seen, 1'b1);
    check(o_flags, 8'h1C);
  endtask
  // All short mask test forms, V set beforehand
  task automatic t_short();
    logic [7:0] op;
    for (int i = 0; i < 12; i++) begin
      op = (i < 6) ? OP_CMT_FIRST + 8'(i) : OP_MBT_FIRST + 8'(i - 6);
      run(op, 8'hE1, 8'h42, 8'h00, (i % 6 < 2) ? LEN_2 : LEN_3,
          (i % 2 == 1) ? 4 : 3);
      check(o_flags & 8'h9C, 8'h0C);
    end
  endtask
  task automatic t_swap();
    run(OP_SWAP_R, 8'h21, 8'h00, 8'h00, LEN_2, 2);
    check(o_flags & 8'h0C, 8'h0C);
    run(OP_SWAP_IR, 8'h22, 8'h00, 8'h00, LEN_2, 3);
    check(o_flags & 8'h0C, 8'h0C);
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_illegal();
    t_trap();
    t_wide();
    t_wdr();
    t_short();
    t_swap();
    print_verdict();
  end
endmodule

// ### bench/ctd_prog_mem.sv
// Program memory model that answers trap vector reads
`timescale 1ns/1ps
module ctd_prog_mem (
  input wire logic [8:0] i_vec_addr,
  output logic [15:0] o_vec_data
);
  // ----------------------------------------------------------------------
  // Vector table
  // ----------------------------------------------------------------------
  // Word pattern differs for every address, so a wrong fetch shows up
  // Top address bit folds into the high byte so every bit is looked at
  assign o_vec_data = {i_vec_addr[7:0] ^ {7'h00, i_vec_addr[8]},
                       ~i_vec_addr[7:0]};
endmodule

// ### design/ctd_core.sv
// Decode and execute slice: wide subtract, nibble swap, mask tests, trap, wdr
//
// What this block does
// - 28 subtracts wide register source, 29 subtracts constant byte.
// - Wide subtract sets C Z S V H from result, D=1; 4 bytes, 3 cycles.
// - F0 swaps register nibbles directly, F1 through a pointer register.
// - Swap sets Z and S, C and V undefined, D and H kept.
// - Opcodes 62..67 test NOT dst AND src over six operand pairings.
// - 62/63 fetch 2 bytes, others 3; pointer forms 4 cycles, else 3.
// - 68/69 do the wide complement mask test, 4 bytes, 3 cycles.
// - Opcodes 72..77 test dst AND src with the same sizes and timing.
// - All mask tests set Z and S, clear V, keep C, D, H.
// - 78/79 do the wide mask bit test, 4 bytes, 3 cycles.
// - F2 pushes PC then flags, loads PC from vector; 2 bytes, 6 cycles.
// - 5F refreshes the watchdog, keeps flags, takes 2 cycles.
`timescale 1ns/1ps
module ctd_core #(
  parameter int MEM_AW = 12
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ins_valid,
  input wire logic [7:0] i_ins_op,
  input wire logic [7:0] i_ins_b1,
  input wire logic [7:0] i_ins_b2,
  input wire logic [7:0] i_ins_b3,
  input wire logic [15:0] i_vec_data,
  output logic o_ins_ready,
  output logic [2:0] o_fetch_len,
  output logic o_done,
  output logic o_illegal,
  output logic o_wdt_refresh,
  output logic [8:0] o_vec_addr,
  output logic [15:0] o_pc,
  output logic [11:0] o_sp,
  output logic [7:0] o_flags
);
  import ctd_pkg::*;

  // ----------------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------------
  typedef struct packed {
    ctd_state_t st;
    logic [2:0] cnt;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [15:0] pc;
    logic [11:0] sp;
    logic [7:0] flags;
    logic [2:0] len;
    logic [8:0] vec;
    logic done;
    logic ill;
    logic wdr;
  } ctd_core_t;

  ctd_core_t st_r;
  ctd_core_t st_nxt;
  logic [7:0] mem_r [0:(1<<MEM_AW)-1];
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [7:0] mem_wd;

  // Fetch length (low 3 bits) and cycles (high 3 bits); zero means illegal
  function automatic logic [5:0] op_size(input logic [7:0] op);
    logic [3:0] lo;
    lo = op[3:0];
    op_size = 6'h00;
    if (op == OP_WSUB_ER || op == OP_WSUB_IM || op == OP_CMTW_ER ||
        op == OP_CMTW_IM || op == OP_MBTW_ER || op == OP_MBTW_IM) begin
      op_size = {CYC_3, LEN_4};
    end else if ((op >= OP_CMT_FIRST && op <= OP_CMT_LAST) ||
                 (op >= OP_MBT_FIRST && op <= OP_MBT_LAST)) begin
      // Odd low nibble means a pointer operand
      op_size = {(lo[0] ? CYC_4 : CYC_3), (lo < 4'h4 ? LEN_2 : LEN_3)};
    end else if (op == OP_SWAP_R) begin
      op_size = {CYC_2, LEN_2};
    end else if (op == OP_SWAP_IR) begin
      op_size = {CYC_3, LEN_2};
    end else if (op == OP_TRAP) begin
      op_size = {CYC_6, LEN_2};
    end else if (op == OP_WDR) begin
      op_size = {CYC_2, LEN_1};
    end
  endfunction

  // Widen an 8-bit register address into the data space
  function automatic logic [MEM_AW-1:0] ra(input logic [7:0] a);
    ra = MEM_AW'(a);
  endfunction

  // Working register nibble to data address
  function automatic logic [MEM_AW-1:0] wa(input logic [3:0] n);
    wa = MEM_AW'(WREG_BASE + {8'h00, n});
  endfunction

  // ----------------------------------------------------------------------
  // Operand fetch and arithmetic
  // ----------------------------------------------------------------------
  logic [MEM_AW-1:0] dst_a;
  logic [7:0] src_v;
  logic [7:0] dst_v;
  logic [8:0] diff;
  logic [4:0] hdiff;
  logic [7:0] res;
  logic [5:0] sz;

  // Operand addressing per form
  always_comb begin
    dst_a = ra(st_r.b2);
    src_v = mem_r[ra(st_r.b1)];
    case (st_r.op[3:0])
      4'h8: begin
        src_v = mem_r[MEM_AW'({st_r.b1, st_r.b2[7:4]})];
        dst_a = MEM_AW'({st_r.b2[3:0], st_r.b3});
      end
      4'h9: begin
        src_v = st_r.b1; // constant_byte source
        dst_a = MEM_AW'({st_r.b2[3:0], st_r.b3});
      end
      4'h2: begin
        src_v = mem_r[wa(st_r.b1[3:0])];
        dst_a = wa(st_r.b1[7:4]);
      end
      4'h3: begin
        src_v = mem_r[ra(mem_r[wa(st_r.b1[3:0])])]; // via_pointer_reg
        dst_a = wa(st_r.b1[7:4]);
      end
      4'h5: src_v = mem_r[ra(mem_r[ra(st_r.b1)])];
      4'h6: begin
        src_v = st_r.b2;
        dst_a = ra(st_r.b1);
      end
      4'h7: begin
        src_v = st_r.b2;
        dst_a = ra(mem_r[ra(st_r.b1)]);
      end
      default: ;
    endcase
    if (st_r.op == OP_SWAP_R) begin
      dst_a = ra(st_r.b1);
    end else if (st_r.op == OP_SWAP_IR) begin
      dst_a = ra(mem_r[ra(st_r.b1)]);
    end
    dst_v = mem_r[dst_a];
  end

  assign diff = {1'b0, dst_v} - {1'b0, src_v};
  assign hdiff = {1'b0, dst_v[3:0]} - {1'b0, src_v[3:0]};
  assign sz = op_size(i_ins_op);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.ill = 1'b0;
    st_nxt.wdr = 1'b0;
    mem_we = 1'b0;
    mem_wa = dst_a;
    mem_wd = 8'h00;
    res = 8'h00;
    case (st_r.st)
      ST_IDLE: begin
        if (i_ins_valid) begin
          if (sz == 6'h00) begin
            st_nxt.ill = 1'b1;
          end else begin
            st_nxt.st = ST_EXEC;
            st_nxt.cnt = sz[5:3] - 3'h1;
            st_nxt.len = sz[2:0];
            st_nxt.pc = st_r.pc + {13'h0000, sz[2:0]};
            st_nxt.op = i_ins_op;
            st_nxt.b1 = i_ins_b1;
            st_nxt.b2 = i_ins_b2;
            st_nxt.b3 = i_ins_b3;
            st_nxt.vec = {i_ins_b1, 1'b0};
          end
        end
      end
      ST_EXEC: begin
        st_nxt.cnt = st_r.cnt - 3'h1;
        if (st_r.op == OP_TRAP) begin
          // Push return address, then flags
          case (st_r.cnt)
            3'h5: begin
              st_nxt.sp = st_r.sp - 12'h002;
              mem_we = 1'b1;
              mem_wa = MEM_AW'(st_r.sp - 12'h002);
              mem_wd = st_r.pc[15:8];
            end
            3'h4: begin
              mem_we = 1'b1;
              mem_wa = MEM_AW'(st_r.sp + 12'h001);
              mem_wd = st_r.pc[7:0];
            end
            3'h3: begin
              st_nxt.sp = st_r.sp - 12'h001;
              mem_we = 1'b1;
              mem_wa = MEM_AW'(st_r.sp - 12'h001);
              mem_wd = st_r.flags;
            end
            3'h0: st_nxt.pc = i_vec_data;
            default: ;
          endcase
        end
        if (st_r.cnt == 3'h0) begin
          st_nxt.st = ST_IDLE;
          st_nxt.done = 1'b1;
          if (st_r.op == OP_WSUB_ER || st_r.op == OP_WSUB_IM) begin
            res = diff[7:0];
            mem_we = 1'b1;
            mem_wd = res;
            st_nxt.flags[FL_C] = diff[8];
            st_nxt.flags[FL_H] = hdiff[4];
            st_nxt.flags[FL_V] = (dst_v[7] ^ src_v[7]) & (dst_v[7] ^ res[7]);
            st_nxt.flags[FL_D] = 1'b1;
          end else if (st_r.op == OP_SWAP_R || st_r.op == OP_SWAP_IR) begin
            res = {dst_v[3:0], dst_v[7:4]};
            mem_we = 1'b1;
            mem_wd = res; // C, V left as they were
          end else if (st_r.op[7:4] == 4'h6 || st_r.op[7:4] == 4'h7) begin
            // Flags only, no write back
            res = (st_r.op[4] ? dst_v : ~dst_v) & src_v;
            st_nxt.flags[FL_V] = 1'b0;
          end else if (st_r.op == OP_WDR) begin
            st_nxt.wdr = 1'b1;
          end
          if (st_r.op != OP_TRAP && st_r.op != OP_WDR) begin
            st_nxt.flags[FL_Z] = (res == 8'h00);
            st_nxt.flags[FL_S] = res[7];
          end
        end
      end
      default: st_nxt.st = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Core state
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_r <= '0;
      st_r.st <= ST_IDLE;
      st_r.pc <= PC_RESET;
      st_r.sp <= SP_RESET;
      st_r.flags <= FLAGS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Data register space
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem_r[mem_wa] <= mem_wd;
    end
  end

  assign o_ins_ready = (st_r.st == ST_IDLE);
  assign o_fetch_len = st_r.len;
  assign o_done = st_r.done;
  assign o_illegal = st_r.ill;
  assign o_wdt_refresh = st_r.wdr;
  assign o_vec_addr = st_r.vec;
  assign o_pc = st_r.pc;
  assign o_sp = st_r.sp;
  assign o_flags = st_r.flags;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic take;
  assign take = i_ins_valid && o_ins_ready && sz != 6'h00;

  sequence take_op(logic [7:0] op);
    take && i_ins_op == op;
  endsequence

  wsub_timing_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take_op(OP_WSUB_ER) |=> !o_done [*3] ##1 o_done && o_flags[FL_D]
      && o_fetch_len == LEN_4) else $error("wide subtract timing or D flag");
  wsub_carry_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take_op(OP_WSUB_IM) |=> ##3 o_flags[FL_C] == $past(diff[8]))
    else $error("wide subtract carry wrong");
  swap_ir_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take_op(OP_SWAP_IR) |=> ##3 o_done && o_fetch_len == LEN_2)
    else $error("indirect swap timing");
  swap_dh_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take_op(OP_SWAP_R) |=> ##2 o_flags[FL_D:FL_H] ==
      $past(o_flags[FL_D:FL_H], 2))
    else $error("swap changed D or H");
  cmt_ptr_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take_op(8'h63) |=> !o_done [*4] ##1 o_done && o_fetch_len == LEN_2)
    else $error("pointer mask test timing");
  mtest_flags_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_done && ($past(st_r.op[7:4]) == 4'h6 || $past(st_r.op[7:4]) == 4'h7)
    |-> !o_flags[FL_V] && o_flags[FL_C] == $past(o_flags[FL_C], 2))
    else $error("mask test flags wrong");
  mtest_nowrite_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st_r.st == ST_EXEC && (st_r.op[7:4] == 4'h6 || st_r.op[7:4] == 4'h7)
    |-> !mem_we) else $error("mask test wrote a result");
  wide_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take_op(OP_MBTW_IM) |=> o_fetch_len == LEN_4 ##3 o_done)
    else $error("wide mask test size");
  trap_seq_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take_op(OP_TRAP) |=> ##6 o_done && o_sp == $past(o_sp, 6) - 12'h003
      && o_pc == $past(i_vec_data) && o_flags == $past(o_flags, 6))
    else $error("trap sequence wrong");
  wdr_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    take_op(OP_WDR) |=> !o_wdt_refresh [*2] ##1 o_wdt_refresh && o_done
      && o_flags == $past(o_flags, 3)) else $error("watchdog refresh wrong");
endmodule

// ### design/ctd_pkg.sv
// Package with opcodes, flag positions, timing and reset values of the decoder
package ctd_pkg;
  // ----------------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_WSUB_ER = 8'h28;
  localparam logic [7:0] OP_WSUB_IM = 8'h29;
  localparam logic [7:0] OP_SWAP_R = 8'hF0;
  localparam logic [7:0] OP_SWAP_IR = 8'hF1;
  localparam logic [7:0] OP_CMT_FIRST = 8'h62;
  localparam logic [7:0] OP_CMT_LAST = 8'h67;
  localparam logic [7:0] OP_CMTW_ER = 8'h68;
  localparam logic [7:0] OP_CMTW_IM = 8'h69;
  localparam logic [7:0] OP_MBT_FIRST = 8'h72;
  localparam logic [7:0] OP_MBT_LAST = 8'h77;
  localparam logic [7:0] OP_MBTW_ER = 8'h78;
  localparam logic [7:0] OP_MBTW_IM = 8'h79;
  localparam logic [7:0] OP_TRAP = 8'hF2;
  localparam logic [7:0] OP_WDR = 8'h5F;
  // ----------------------------------------------------------------------
  // Flag bit positions inside the flag byte
  // ----------------------------------------------------------------------
  localparam int FL_C = 7;
  localparam int FL_Z = 6;
  localparam int FL_S = 5;
  localparam int FL_V = 4;
  localparam int FL_D = 3;
  localparam int FL_H = 2;
  // ----------------------------------------------------------------------
  // Fetch lengths and execution cycle counts
  // ----------------------------------------------------------------------
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_4 = 3'h4;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;
  localparam logic [2:0] CYC_6 = 3'h6;
  // ----------------------------------------------------------------------
  // Reset values and address layout
  // ----------------------------------------------------------------------
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [11:0] SP_RESET = 12'h000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [11:0] WREG_BASE = 12'h0E0;
  // ----------------------------------------------------------------------
  // Execution states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } ctd_state_t;
endpackage
